// ---- dv/baseline_core_insn_subset_tb_top.sv ----
`timescale 1ns/100ps
`include "core_subset_consts.vh"
module baseline_core_insn_subset_tb_top;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire  [7:0]  cfg_out;
    wire         asleep;
    wire         retire_pulse;
    wire         hready = hreadyout;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cyc = 0;
    logic [31:0] q, fb, c0, p0;
    logic [10:0] e;
    logic [7:0]  k, fv, av;
    logic [5:0]  hi;
    logic [4:0]  f;
    logic [2:0]  fl;
    logic [1:0]  op;
    logic        d, wk;
    insn_subset_core uut (
        .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cfg_out(cfg_out), .asleep(asleep),
        .retire_pulse(retire_pulse));
    always #12.5 clk_sys = ~clk_sys;
    task automatic finish_test();
        if (n_mismatch == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // generous ceiling: the whole sequence needs under 4000 cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] dv, output logic [31:0] rv);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dv;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        rv = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dv);
        logic [31:0] rv;
        bus(1'b1, a, dv, rv);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] rv);
        bus(1'b0, a, 32'h0, rv);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] exp);
        logic [31:0] rv;
        bus(1'b0, a, 32'h0, rv);
        chk(rv & m, exp);
    endtask
    // spacing covers the flush cycle of a return as well
    task automatic exec(input logic [11:0] w);
        wr(`OFS_INSN, {20'h0, w});
        repeat (4) @(posedge clk_sys);
    endtask
    // result in 7:0, then carry, half carry, zero above it
    function automatic logic [10:0] alu_exp(input logic [1:0] o,
        input logic [7:0] fr, input logic [7:0] ac, input logic [2:0] fo);
        logic [7:0] s;
        s = fr - ac;
        if (o == 2'd0)
            return {fo[2], fo[1], fr[7], fr[6:0], fo[0]};
        if (o == 2'd1)
            return {fo[2], fo[1], fr[0], fo[0], fr[7:1]};
        return {s == 8'h00, fr[3:0] >= ac[3:0], fr >= ac, s};
    endfunction
    initial begin
        void'($urandom(75594));
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            k = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            rd(`OFS_FLAGS, fb);
            exec({`OP_LOAD_LITERAL_ACC_HI, k});
            rd_chk(`OFS_ACC, 32'hFF, {24'h0, k});
            exec(`OP_CFG_LOAD);
            chk({24'h0, cfg_out}, {24'h0, k});
            rd_chk(`OFS_FLAGS, 32'h3F, fb & 32'h3F);
            c0 = $urandom & 32'h1FF;
            wr(`OFS_STACK, c0);
            rd(`OFS_CYCLES, q);
            exec({`OP_RETURN_WITH_LITERAL_HI, ~k});
            rd_chk(`OFS_ACC, 32'hFF, {24'h0, ~k});
            rd_chk(`OFS_PC, 32'h1FF, c0);
            rd_chk(`OFS_CYCLES, 32'hFFFFFFFF, q + 32'd2);
            rd_chk(`OFS_FLAGS, 32'h3F, fb & 32'h3F);
            rd(`OFS_PC, p0);
            rd(`OFS_CYCLES, q);
            exec(`OP_IDLE);
            rd_chk(`OFS_PC, 32'h1FF, (p0 + 32'd1) & 32'h1FF);
            rd_chk(`OFS_CYCLES, 32'hFFFFFFFF, q + 32'd1);
            rd_chk(`OFS_ACC, 32'hFF, {24'h0, ~k});
            rd_chk(`OFS_FLAGS, 32'h3F, fb & 32'h3F);
        end
        for (int i = 0; i < 60; i++) begin
            op = 2'(i % 3);
            d = 1'((i / 3) % 2);
            f = 5'($urandom);
            fv = 8'($urandom);
            av = (i < 6) ? fv : 8'($urandom);
            fl = 3'($urandom);
            wk = 1'($urandom);
            hi = (op == 2'd0) ? `OP_RL_HI : (op == 2'd1) ? `OP_RR_HI
                                                        : `OP_SUB_HI;
            wr(`OFS_FILE_BASE + {f, 2'b00}, {24'h0, fv});
            wr(`OFS_ACC, {24'h0, av});
            wr(`OFS_FLAGS, {26'h0, wk, 2'b00, fl});
            exec({hi, d, f});
            e = alu_exp(op, fv, av, fl);
            rd_chk(`OFS_FILE_BASE + {f, 2'b00}, 32'hFF,
                   {24'h0, d ? e[7:0] : fv});
            rd_chk(`OFS_ACC, 32'hFF, {24'h0, d ? av : e[7:0]});
            rd_chk(`OFS_FLAGS, 32'h3F,
                   {26'h0, wk, 2'b11, e[10:8]});
        end
        // reads fall just before and just after the first prescaler
        // wrap, which lands 256 clocks after sleep only if both cleared
        wr(`OFS_FLAGS, 32'h20);
        exec(`OP_SLEEP);
        chk({31'h0, asleep}, 32'h1);
        repeat (240) @(posedge clk_sys);
        rd_chk(`OFS_WDT, 32'hFF, 32'h0);
        rd_chk(`OFS_FLAGS, 32'h138, 32'h130);
        repeat (10) @(posedge clk_sys);
        rd_chk(`OFS_WDT, 32'hFF, 32'h1);
        rd(`OFS_ACC, q);
        exec({`OP_LOAD_LITERAL_ACC_HI, ~q[7:0]});
        rd_chk(`OFS_ACC, 32'hFF, q & 32'hFF);
        rd_chk(`OFS_FLAGS, 32'h40, 32'h40);
        wr(`OFS_CTRL, 32'h1);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, asleep}, 32'h0);
        finish_test();
    end
endmodule

// ---- dv/core_rules_chk_assertions.sv ----
`timescale 1ns/100ps
`include "core_subset_consts.vh"
module core_rules_chk (
    input wire        clk_sys,
    input wire        srst,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire        hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire [7:0]  cfg_out,
    input wire        asleep,
    input wire        retire_pulse
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic insn_q;
    logic ctrl_q;
    wire  take = hsel && htrans[1] && hready && hwrite;
    wire  go = insn_q && !asleep;
    wire  cfg_go = go && hwdata[11:0] == `OP_CFG_LOAD;
    wire  slp_go = go && hwdata[11:0] == `OP_SLEEP;
    wire  ret_go = go && hwdata[11:8] == `OP_RETURN_WITH_LITERAL_HI;
    wire  plain_go = go && !ret_go && !slp_go;
    wire  wake = ctrl_q && hwdata[`CT_WAKE];
    // flags mark the data-phase edge, where hwdata holds the word
    always @(posedge clk_sys) begin
        if (srst) begin
            insn_q <= 1'b0;
            ctrl_q <= 1'b0;
        end else begin
            insn_q <= take && haddr == {24'h0, `OFS_INSN};
            ctrl_q <= take && haddr == {24'h0, `OFS_CTRL};
        end
    end
    cfg_cause_a: assert property (
        $changed(cfg_out) |-> $past(cfg_go) || $past(cfg_go, 2))
        else $error("config output moved without a config load");
    ret_timing_a: assert property (
        ret_go |-> ##2 !retire_pulse ##1 retire_pulse)
        else $error("return did not retire after two cycles");
    plain_timing_a: assert property (
        plain_go |-> ##2 retire_pulse)
        else $error("instruction did not retire in one cycle");
    retire_once_a: assert property (
        retire_pulse |=> !retire_pulse)
        else $error("retire pulse longer than one cycle");
    sleep_entry_a: assert property (
        slp_go |-> ##[1:2] asleep)
        else $error("power-down did not stop the core");
    sleep_cause_a: assert property (
        $rose(asleep) |-> $past(slp_go) || $past(slp_go, 2))
        else $error("core slept without a power-down");
    sleep_quiet_a: assert property (
        asleep |-> !retire_pulse)
        else $error("instruction retired while asleep");
    wake_cause_a: assert property (
        $fell(asleep) |-> $past(wake) || $past(wake, 2))
        else $error("core woke without a wake request");
    sleep_hold_a: assert property (
        asleep && !wake && !$past(wake) |=> asleep)
        else $error("sleep ended on its own");
    bus_okay_a: assert property (
        hreadyout && !hresp)
        else $error("slave stalled or answered with an error");
endmodule
bind insn_subset_core core_rules_chk chk_i (
    .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cfg_out(cfg_out), .asleep(asleep),
    .retire_pulse(retire_pulse));

// ---- verilog/core_subset_consts.vh ----
`ifndef CORE_SUBSET_CONSTS_VH
`define CORE_SUBSET_CONSTS_VH

// register byte offsets
`define OFS_INSN        8'h00
`define OFS_ACC         8'h04
`define OFS_FLAGS       8'h08
`define OFS_CFG         8'h0C
`define OFS_PC          8'h10
`define OFS_STACK       8'h14
`define OFS_WDT         8'h18
`define OFS_CTRL        8'h1C
`define OFS_CYCLES      8'h20
`define OFS_FILE_BASE   8'h80

// flags register field positions
`define FL_CARRY        0
`define FL_HALF         1
`define FL_ZERO         2
`define FL_PWRDN        3
`define FL_EXPIRY       4
`define FL_WAKE         5
`define FL_REFUSED      6
`define FL_BUSY         7
`define FL_ASLEEP       8
`define FL_ILLEGAL      9

// control register field positions
`define CT_WAKE         0

// 12-bit instruction encodings
`define OP_IDLE         12'h000
`define OP_CFG_LOAD     12'h002
`define OP_SLEEP        12'h003
`define OP_SUB_HI       6'h02
`define OP_RR_HI        6'h0C
`define OP_RL_HI        6'h0D
`define OP_RETURN_WITH_LITERAL_HI     4'h8
`define OP_LOAD_LITERAL_ACC_HI     4'hC

// reset values
`define RST_ACC         8'h00
`define RST_CFG         8'hFF
`define RST_PC          9'h1FF
`define RST_STACK       9'h000
`define RST_EXPIRY      1'b1
`define RST_PWRDN       1'b1

// alu operation select
`define ALU_RL          2'h0
`define ALU_RR          2'h1
`define ALU_SUB         2'h2

`endif

// ---- verilog/insn_subset_core.v ----
// Notes on behaviour
// - load literal puts the 8-bit immediate into the accumulator, flags kept
// - config load copies the whole accumulator into the config register
// - return loads immediate into accumulator, PC from stack top, flags kept
// - return takes two instruction cycles, the prefetched one is dropped
// - power-down clears the watchdog counter and its prescaler
// - power-down sets expiry flag, clears power-down flag, wake flag kept
// - power-down stops the core; no instruction runs while asleep
// - rotate left through carry: bit 7 to carry, carry to bit 0
// - rotate right through carry: bit 0 to carry, carry to bit 7
// - destination bit 0 writes the accumulator, 1 writes the file register
// - subtract computes file minus accumulator, updates carry, half, zero
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "core_subset_consts.vh"
module insn_subset_core (
    input  wire        clk_sys,
    input  wire        srst,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire        hready,
    input  wire [31:0] hwdata,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg  [7:0]  cfg_out,
    output reg         asleep,
    output reg         retire_pulse
);

    // one instruction in flight at a time; flush is the dropped prefetch
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_EXEC  = 4'b0010;
    localparam [3:0] ST_FLUSH = 4'b0100;
    localparam [3:0] ST_SLEEP = 4'b1000;

    // one-hot instruction classes
    localparam [7:0] C_IDLE  = 8'h01;
    localparam [7:0] C_LOAD_LITERAL_ACC = 8'h02;
    localparam [7:0] C_CFG   = 8'h04;
    localparam [7:0] C_RETURN_WITH_LITERAL = 8'h08;
    localparam [7:0] C_SLEEP = 8'h10;
    localparam [7:0] C_RL    = 8'h20;
    localparam [7:0] C_RR    = 8'h40;
    localparam [7:0] C_SUB   = 8'h80;

    // one-hot class of a 12-bit instruction word, zero when not decoded
    function [7:0] insn_class;
        input [11:0] w;
        begin
            if (w == `OP_IDLE)
                insn_class = C_IDLE;
            else if (w == `OP_CFG_LOAD)
                insn_class = C_CFG;
            else if (w == `OP_SLEEP)
                insn_class = C_SLEEP;
            else if (w[11:8] == `OP_LOAD_LITERAL_ACC_HI)
                insn_class = C_LOAD_LITERAL_ACC;
            else if (w[11:8] == `OP_RETURN_WITH_LITERAL_HI)
                insn_class = C_RETURN_WITH_LITERAL;
            else if (w[11:6] == `OP_RL_HI)
                insn_class = C_RL;
            else if (w[11:6] == `OP_RR_HI)
                insn_class = C_RR;
            else if (w[11:6] == `OP_SUB_HI)
                insn_class = C_SUB;
            else
                insn_class = 8'h00;
        end
    endfunction

    // word-aligned decode of a file register address
    function is_file;
        input [7:0] a;
        begin
            is_file = (a[7] == 1'b1) && (a[1:0] == 2'b00);
        end
    endfunction

    // zero-extend a byte register onto the read bus
    function [31:0] byte_word;
        input [7:0] b;
        begin
            byte_word = {24'h00_0000, b};
        end
    endfunction

    reg [3:0]  state_q;
    reg [11:0] insn_q;
    reg [7:0]  acc_q;
    reg        carry_q;
    reg        half_q;
    reg        zero_q;
    reg        pwrdn_q;
    reg        expiry_q;
    reg        wake_q;
    reg        refused_q;
    reg        illegal_q;
    // pc is 9 bits and simply wraps; this subset has no page bits
    reg [8:0]  pc_q;
    reg [8:0]  stack_q;
    reg [7:0]  wdt_q;
    reg [7:0]  wdt_pre_q;
    reg [31:0] cycles_q;
    reg [7:0]  file_q [0:31];

    // latched address phase
    reg        wr_pend_q;
    reg [7:0]  wr_addr_q;

    // hreadyout never drops, so a taken address phase is answered next
    wire        addr_ok = hsel & htrans[1] & hready;
    wire [7:0]  cls     = insn_class(insn_q);
    wire [4:0]  faddr   = insn_q[4:0];
    wire        dest    = insn_q[5];
    wire [7:0]  fval    = file_q[faddr];
    wire        core_rdy = (state_q == ST_IDLE);

    reg  [1:0]  alu_op;
    wire [7:0]  alu_res;
    wire        alu_c;
    wire        alu_dc;
    wire        alu_z;

    always @* begin
        case (cls)
            C_RL:    alu_op = `ALU_RL;
            C_RR:    alu_op = `ALU_RR;
            default: alu_op = `ALU_SUB;
        endcase
    end

    rotate_sub_unit alu (
        .op        (alu_op),
        .file_val  (fval),
        .acc_val   (acc_q),
        .carry_in  (carry_q),
        .half_in   (half_q),
        .result    (alu_res),
        .carry_out (alu_c),
        .half_out  (alu_dc),
        .zero_out  (alu_z)
    );

    // alu results land only in the exec cycle; flush writes nothing
    wire exec_now = (state_q == ST_EXEC);
    wire is_alu   = (cls == C_RL) | (cls == C_RR) | (cls == C_SUB);
    wire to_acc   = exec_now & is_alu & ~dest;
    wire to_file  = exec_now & is_alu & dest;

    wire bus_wr    = wr_pend_q;
    wire wr_insn   = bus_wr & (wr_addr_q == `OFS_INSN);
    wire wr_acc    = bus_wr & (wr_addr_q == `OFS_ACC);
    wire wr_flags  = bus_wr & (wr_addr_q == `OFS_FLAGS);
    wire wr_stack  = bus_wr & (wr_addr_q == `OFS_STACK);
    wire wr_ctrl   = bus_wr & (wr_addr_q == `OFS_CTRL);
    wire wr_file   = bus_wr & is_file(wr_addr_q);

    // status word as software reads it; busy spans exec and flush
    wire        busy_now = (state_q == ST_EXEC) | (state_q == ST_FLUSH);
    wire [15:0] flags_rd = {6'h00, illegal_q, (state_q == ST_SLEEP),
                            busy_now, refused_q, wake_q, expiry_q,
                            pwrdn_q, zero_q, half_q, carry_q};

    // bus slave: zero wait states, reads answered from a flop
    always @(posedge clk_sys) begin
        if (srst) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_q <= addr_ok & hwrite;
            wr_addr_q <= haddr[7:0];
            if (addr_ok & ~hwrite) begin
                // any address bit above the low byte misses every register
                if (haddr[31:8] != 24'h00_0000)
                    hrdata <= 32'h0000_0000;
                else if (is_file(haddr[7:0]))
                    hrdata <= byte_word(file_q[haddr[6:2]]);
                else begin
                    case (haddr[7:0])
                        `OFS_ACC:    hrdata <= byte_word(acc_q);
                        `OFS_FLAGS:  hrdata <= {16'h0000, flags_rd};
                        `OFS_CFG:    hrdata <= byte_word(cfg_out);
                        `OFS_PC:     hrdata <= {23'h0, pc_q};
                        `OFS_STACK:  hrdata <= {23'h0, stack_q};
                        `OFS_WDT:    hrdata <= byte_word(wdt_q);
                        `OFS_CYCLES: hrdata <= cycles_q;
                        default:     hrdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // sequencing of one instruction at a time
    always @(posedge clk_sys) begin
        if (srst) begin
            state_q      <= ST_IDLE;
            insn_q       <= `OP_IDLE;
            asleep       <= 1'b0;
            retire_pulse <= 1'b0;
            pc_q         <= `RST_PC;
            cycles_q     <= 32'h0000_0000;
        end else begin
            retire_pulse <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (wr_insn) begin
                        insn_q  <= hwdata[11:0];
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    cycles_q <= cycles_q + 32'h0000_0001;
                    if (cls == C_RETURN_WITH_LITERAL) begin
                        pc_q    <= stack_q;
                        state_q <= ST_FLUSH;
                    end else if (cls == C_SLEEP) begin
                        // no retire pulse: the core stops instead
                        pc_q    <= pc_q + 9'h001;
                        state_q <= ST_SLEEP;
                        asleep  <= 1'b1;
                    end else begin
                        pc_q         <= pc_q + 9'h001;
                        retire_pulse <= 1'b1;
                        state_q      <= ST_IDLE;
                    end
                end
                ST_FLUSH: begin
                    // the prefetched slot retires as a bubble
                    cycles_q     <= cycles_q + 32'h0000_0001;
                    retire_pulse <= 1'b1;
                    state_q      <= ST_IDLE;
                end
                ST_SLEEP: begin
                    // only a wake command restarts the core
                    if (wr_ctrl & hwdata[`CT_WAKE]) begin
                        asleep  <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    asleep  <= 1'b0;
                end
            endcase
        end
    end

    // accumulator, flags, config and stack; execution wins over the bus
    always @(posedge clk_sys) begin
        if (srst) begin
            acc_q     <= `RST_ACC;
            cfg_out   <= `RST_CFG;
            stack_q   <= `RST_STACK;
            carry_q   <= 1'b0;
            half_q    <= 1'b0;
            zero_q    <= 1'b0;
            pwrdn_q   <= `RST_PWRDN;
            expiry_q  <= `RST_EXPIRY;
            wake_q    <= 1'b0;
            refused_q <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            if (wr_acc)
                acc_q <= hwdata[7:0];
            if (wr_stack)
                stack_q <= hwdata[8:0];
            // expiry and power-down bits stay read-only to software
            if (wr_flags) begin
                carry_q <= hwdata[`FL_CARRY];
                half_q  <= hwdata[`FL_HALF];
                zero_q  <= hwdata[`FL_ZERO];
                wake_q  <= hwdata[`FL_WAKE];
                if (hwdata[`FL_REFUSED])
                    refused_q <= 1'b0;
                if (hwdata[`FL_ILLEGAL])
                    illegal_q <= 1'b0;
            end
            // a refusal in the clearing cycle still sticks
            if (wr_insn & ~core_rdy)
                refused_q <= 1'b1;
            if (exec_now) begin
                case (cls)
                    C_LOAD_LITERAL_ACC: acc_q <= insn_q[7:0];
                    C_CFG:   cfg_out <= acc_q;
                    C_RETURN_WITH_LITERAL: acc_q <= insn_q[7:0];
                    C_SLEEP: begin
                        expiry_q <= 1'b1;
                        pwrdn_q  <= 1'b0;
                    end
                    C_RL, C_RR: begin
                        carry_q <= alu_c;
                    end
                    C_SUB: begin
                        carry_q <= alu_c;
                        half_q  <= alu_dc;
                        zero_q  <= alu_z;
                    end
                    C_IDLE: begin
                        acc_q <= acc_q;
                    end
                    // undecoded words still advance pc; only the flag tells
                    default: illegal_q <= 1'b1;
                endcase
                // last assignment, so a same-edge bus write to acc loses
                if (to_acc)
                    acc_q <= alu_res;
            end
        end
    end

    // file registers: single write port, execution has priority
    // a bus write that meets an exec write-back in one edge is lost
    always @(posedge clk_sys) begin
        if (to_file)
            file_q[faddr] <= alu_res;
        else if (wr_file)
            file_q[wr_addr_q[6:2]] <= hwdata[7:0];
    end

    // watchdog keeps counting in sleep, it runs from its own timebase
    // no time-out action here: the counter is only observed on the bus
    always @(posedge clk_sys) begin
        if (srst) begin
            wdt_q     <= 8'h00;
            wdt_pre_q <= 8'h00;
        end else if (exec_now & (cls == C_SLEEP)) begin
            wdt_q     <= 8'h00;
            wdt_pre_q <= 8'h00;
        end else begin
            wdt_pre_q <= wdt_pre_q + 8'h01;
            if (wdt_pre_q == 8'hFF)
                wdt_q <= wdt_q + 8'h01;
        end
    end

endmodule

// ---- verilog/rotate_sub_unit.v ----
`timescale 1ns/100ps
`include "core_subset_consts.vh"
module rotate_sub_unit (
    input  wire [1:0] op,
    input  wire [7:0] file_val,
    input  wire [7:0] acc_val,
    input  wire       carry_in,
    input  wire       half_in,
    output reg  [7:0] result,
    output reg        carry_out,
    output reg        half_out,
    output reg        zero_out
);

    reg [8:0] diff;
    reg [4:0] low_diff;

    always @* begin
        diff      = {1'b0, file_val} - {1'b0, acc_val};
        low_diff  = {1'b0, file_val[3:0]} - {1'b0, acc_val[3:0]};
        result    = file_val;
        carry_out = carry_in;
        half_out  = half_in;
        zero_out  = 1'b0;
        case (op)
            `ALU_RL: begin
                result    = {file_val[6:0], carry_in};
                carry_out = file_val[7];
            end
            `ALU_RR: begin
                result    = {carry_in, file_val[7:1]};
                carry_out = file_val[0];
            end
            `ALU_SUB: begin
                result    = diff[7:0];
                carry_out = ~diff[8];
                half_out  = ~low_diff[4];
                zero_out  = (diff[7:0] == 8'h00);
            end
            default: begin
                result    = file_val;
            end
        endcase
    end

endmodule
